// [src/lrd_pkg.sv]
`default_nettype none

package lrd_pkg;

	////////////////////////////////////////////////////////////////////////////
	// sizes

	localparam int NUM_CHANNELS = 4;
	localparam int REG_AW       = 8;
	localparam int REG_DW       = 32;
	localparam int WINDOW_LEN   = 8;
	localparam int FIFO_ADDR_W  = 6;

	////////////////////////////////////////////////////////////////////////////
	// register map, byte addresses

	localparam logic [REG_AW-1:0] CTRL_OFFSET   = 8'h00;
	localparam logic [REG_AW-1:0] STATUS_OFFSET = 8'h04;

	localparam int CTRL_CODE_LSB    = 0;
	localparam int CTRL_SINGLE_BIT  = 2;
	localparam int CTRL_MUTE_BIT    = 3;
	localparam int CTRL_EDGE_BIT    = 4;
	localparam int CTRL_JA_EN_BIT   = 5;
	localparam int CTRL_JA_DEEP_BIT = 6;
	localparam int CTRL_JA_TX_BIT   = 7;
	localparam int CTRL_W           = 8;

	localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;

	localparam int STATUS_LOS_LSB = 0;
	localparam int STATUS_OVF_LSB = 4;

	////////////////////////////////////////////////////////////////////////////
	// jitter attenuator depths, in symbols

	localparam logic [FIFO_ADDR_W:0] JA_DEPTH_SHALLOW = 7'h20;
	localparam logic [FIFO_ADDR_W:0] JA_DEPTH_DEEP    = 7'h40;
	localparam logic [FIFO_ADDR_W:0] BYPASS_THRESHOLD = 7'h01;

	////////////////////////////////////////////////////////////////////////////
	// types

	typedef enum logic [1:0] {
		LRD_AMI  = 2'b00,
		LRD_HDB3 = 2'b01,
		LRD_B8ZS = 2'b10
	} lrd_code_t;

	typedef enum logic {
		LRD_FILLING  = 1'b0,
		LRD_DRAINING = 1'b1
	} lrd_fill_t;

	// one received line symbol; bpv marks a pulse of the same polarity as the last
	typedef struct packed {
		logic pos;
		logic neg;
		logic bpv;
	} lrd_sym_t;

	typedef lrd_sym_t [WINDOW_LEN-1:0] lrd_win_t;

	// one symbol as it leaves the decoder toward the rail outputs
	typedef struct packed {
		logic data_p;
		logic data_n;
		logic cv;
	} lrd_word_t;

	localparam int WORD_W = $bits(lrd_word_t);

endpackage

`default_nettype wire

// [src/lrd_fifo_mem.sv]
`timescale 1ns/10ps
`default_nettype none

module lrd_fifo_mem #(
	parameter int WIDTH  = 3,
	parameter int ADDR_W = 6
) (
	input  wire logic              clock_i,
	input  wire logic              wr_en_i,
	input  wire logic [ADDR_W-1:0] wr_addr_i,
	input  wire logic [WIDTH-1:0]  wr_data_i,
	input  wire logic              rd_en_i,
	input  wire logic [ADDR_W-1:0] rd_addr_i,
	output var  logic [WIDTH-1:0]  rd_data_o
);
	import lrd_pkg::*;

	logic [WIDTH-1:0] store [0:(1<<ADDR_W)-1];

	// no reset: contents are only read after being written
	always_ff @(posedge clock_i) begin
		if (wr_en_i) begin
			store[wr_addr_i] <= wr_data_i;
		end
		if (rd_en_i) begin
			rd_data_o <= store[rd_addr_i];
		end
	end

endmodule // lrd_fifo_mem

`default_nettype wire

// [src/lrd_buffer2.sv]
`timescale 1ns/10ps
`default_nettype none

module lrd_buffer2 #(
	parameter int WIDTH = 3
) (
	input  wire logic             clock_i,
	input  wire logic             sys_rst_i,
	input  wire logic             in_valid_i,
	output var  logic             in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output var  logic             out_valid_o,
	input  wire logic             out_ready_i,
	output var  logic [WIDTH-1:0] out_data_o
);
	import lrd_pkg::*;

	logic [WIDTH-1:0] slot0;
	logic [WIDTH-1:0] slot1;
	logic [1:0]       fill;

	wire push = in_valid_i && in_ready_o;
	wire pop  = out_valid_o && out_ready_i;

	assign in_ready_o  = (fill != 2'h2);
	assign out_valid_o = (fill != 2'h0);
	assign out_data_o  = slot0;

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			fill <= 2'h0;
		end else if (push && !pop) begin
			fill <= fill + 2'h1;
		end else if (pop && !push) begin
			fill <= fill - 2'h1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (pop) begin
			slot0 <= (fill == 2'h2) ? slot1 : in_data_i;
			if (push && fill == 2'h2) begin
				slot1 <= in_data_i;
			end
		end else if (push) begin
			if (fill == 2'h0) begin
				slot0 <= in_data_i;
			end else begin
				slot1 <= in_data_i;
			end
		end
	end

endmodule // lrd_buffer2

`default_nettype wire

// [src/lrd_decode_outputs.sv]
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none

module lrd_decode_outputs #(
	parameter int NCH     = lrd_pkg::NUM_CHANNELS,
	parameter int FIFO_AW = lrd_pkg::FIFO_ADDR_W
) (
	input  wire logic                       clock_i,
	input  wire logic                       sys_rst_i,
	input  wire logic [NCH-1:0]             rclk_i,
	input  wire logic [NCH-1:0]             rx_pos_i,
	input  wire logic [NCH-1:0]             rx_neg_i,
	input  wire logic [NCH-1:0]             los_detect_i,
	input  wire logic [lrd_pkg::REG_AW-1:0] reg_addr_i,
	input  wire logic [lrd_pkg::REG_DW-1:0] reg_wdata_i,
	input  wire logic                       reg_wr_i,
	input  wire logic                       reg_rd_i,
	output var  logic [lrd_pkg::REG_DW-1:0] reg_rdata_o,
	output var  logic [NCH-1:0]             recovered_clock_o,
	output var  logic [NCH-1:0]             positive_rail_out_o,
	output var  logic [NCH-1:0]             negative_rail_out_o,
	output var  logic [NCH-1:0]             loss_of_signal_flag_o
);
	import lrd_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// symbol helpers

	function automatic logic is_pulse(input lrd_sym_t s);
		return s.pos ^ s.neg;
	endfunction

	function automatic logic is_empty(input lrd_sym_t s);
		return !s.pos && !s.neg;
	endfunction

	// c[0] is the newest symbol; a matched substitution is cleared to zeros
	function automatic lrd_win_t restore(input lrd_win_t c, input lrd_code_t code, input logic en);
		lrd_win_t r;
		logic     hit_hdb3;
		logic     hit_b8zs;
		r        = c;
		hit_hdb3 = en && (code == LRD_HDB3)
			&& is_pulse(c[0]) && c[0].bpv
			&& is_empty(c[1]) && is_empty(c[2])
			&& (is_empty(c[3]) || (is_pulse(c[3]) && !c[3].bpv));
		hit_b8zs = en && (code == LRD_B8ZS)
			&& is_empty(c[7]) && is_empty(c[6]) && is_empty(c[5])
			&& is_pulse(c[4]) && c[4].bpv
			&& is_pulse(c[3]) && !c[3].bpv
			&& is_empty(c[2])
			&& is_pulse(c[1]) && c[1].bpv
			&& is_pulse(c[0]) && !c[0].bpv;
		if (hit_hdb3) begin
			r[3:0] = '0;
		end
		if (hit_b8zs) begin
			r[4:0] = '0;
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// register port

	logic [CTRL_W-1:0] ctrl_q;
	logic [NCH-1:0]    ovf_sticky;
	logic [NCH-1:0]    ovf_evt;

	wire ctrl_hit   = (reg_addr_i == CTRL_OFFSET);
	wire status_hit = (reg_addr_i == STATUS_OFFSET);

	wire [NCH-1:0] ovf_clear = (reg_wr_i && status_hit) ? reg_wdata_i[STATUS_OVF_LSB +: NCH] : '0;

	wire [REG_DW-1:0] status_word = (REG_DW'(ovf_sticky) << STATUS_OVF_LSB)
		| (REG_DW'(loss_of_signal_flag_o) << STATUS_LOS_LSB);

	wire [REG_DW-1:0] read_mux = ctrl_hit   ? REG_DW'(ctrl_q) :
	                             status_hit ? status_word    : '0;

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			ctrl_q <= CTRL_RESET;
		end else if (reg_wr_i && ctrl_hit) begin
			ctrl_q <= reg_wdata_i[CTRL_W-1:0];
		end
	end

	// an overflow in the same cycle as its clear stays set
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			ovf_sticky <= '0;
		end else begin
			ovf_sticky <= ovf_evt | (ovf_sticky & ~ovf_clear);
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= '0;
		end else begin
			reg_rdata_o <= reg_rd_i ? read_mux : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// shared configuration

	wire lrd_code_t cfg_code  = lrd_code_t'(ctrl_q[CTRL_CODE_LSB +: 2]);
	wire            cfg_single = ctrl_q[CTRL_SINGLE_BIT];
	wire            cfg_mute   = ctrl_q[CTRL_MUTE_BIT];
	wire            cfg_edge   = ctrl_q[CTRL_EDGE_BIT];
	wire            cfg_ja_rx  = ctrl_q[CTRL_JA_EN_BIT] && !ctrl_q[CTRL_JA_TX_BIT];

	// with the attenuator in the transmit path the receive FIFO only passes words through
	wire [FIFO_AW:0] fifo_limit  = ctrl_q[CTRL_JA_DEEP_BIT] ? JA_DEPTH_DEEP : JA_DEPTH_SHALLOW;
	wire [FIFO_AW:0] fifo_thresh = cfg_ja_rx ? (fifo_limit >> 1) : BYPASS_THRESHOLD;

	////////////////////////////////////////////////////////////////////////////
	// channels

	for (genvar g = 0; g < NCH; g++) begin : g_ch

		logic rclk_s1;
		logic rclk_s2;
		logic rclk_s3;
		logic pos_s1;
		logic pos_s2;
		logic neg_s1;
		logic neg_s2;
		logic los_s1;
		logic los_s2;

		always_ff @(posedge clock_i) begin
			if (sys_rst_i) begin
				rclk_s1 <= 1'h0;
				rclk_s2 <= 1'h0;
				rclk_s3 <= 1'h0;
				pos_s1  <= 1'h0;
				pos_s2  <= 1'h0;
				neg_s1  <= 1'h0;
				neg_s2  <= 1'h0;
				los_s1  <= 1'h0;
				los_s2  <= 1'h0;
			end else begin
				rclk_s1 <= rclk_i[g];
				rclk_s2 <= rclk_s1;
				rclk_s3 <= rclk_s2;
				pos_s1  <= rx_pos_i[g];
				pos_s2  <= pos_s1;
				neg_s1  <= rx_neg_i[g];
				neg_s2  <= neg_s1;
				los_s1  <= los_detect_i[g];
				los_s2  <= los_s1;
			end
		end

		wire rise   = rclk_s2 && !rclk_s3;
		wire fall   = !rclk_s2 && rclk_s3;
		wire launch = cfg_edge ? rise : fall;

		////////////////////////////////////////////////////////////////////////
		// decoder

		lrd_win_t win;
		logic     last_pol;
		logic     seen_pulse;

		wire      new_pulse = pos_s2 ^ neg_s2;
		// both rails at once can never be legal, so it is a violation too
		wire      new_bpv   = (pos_s2 && neg_s2) || (new_pulse && seen_pulse && (pos_s2 == last_pol));
		wire lrd_sym_t new_sym = '{pos: pos_s2, neg: neg_s2, bpv: new_bpv};
		wire lrd_win_t cand    = {win[WINDOW_LEN-2:0], new_sym};
		wire lrd_win_t next_win = restore(cand, cfg_code, cfg_single);

		// the oldest symbol leaves the window; an unmatched violation becomes a code violation
		wire lrd_word_t emit = '{data_p: win[WINDOW_LEN-1].pos,
		                         data_n: win[WINDOW_LEN-1].neg,
		                         cv:     win[WINDOW_LEN-1].bpv};

		always_ff @(posedge clock_i) begin
			if (sys_rst_i) begin
				win        <= '0;
				last_pol   <= 1'h0;
				seen_pulse <= 1'h0;
			end else if (rise) begin
				win <= next_win;
				if (new_pulse) begin
					last_pol   <= pos_s2;
					seen_pulse <= 1'h1;
				end
			end
		end

		////////////////////////////////////////////////////////////////////////
		// elastic FIFO

		logic [FIFO_AW-1:0] wptr;
		logic [FIFO_AW-1:0] rptr;
		logic [FIFO_AW:0]   count;
		lrd_fill_t          fill_st;
		logic               rd_pend;
		logic [WORD_W-1:0]  mem_q;
		logic               buf_in_ready;
		logic               buf_out_valid;
		logic [WORD_W-1:0]  buf_out;

		wire fifo_full = (count >= fifo_limit);
		wire wr_ok     = rise && !fifo_full;
		wire rd_go     = (fill_st == LRD_DRAINING) && (count != '0) && buf_in_ready && !rd_pend;

		assign ovf_evt[g] = rise && fifo_full;

		always_ff @(posedge clock_i) begin
			if (sys_rst_i) begin
				wptr <= '0;
				rptr <= '0;
			end else begin
				if (wr_ok) begin
					wptr <= wptr + 1'h1;
				end
				if (rd_go) begin
					rptr <= rptr + 1'h1;
				end
			end
		end

		always_ff @(posedge clock_i) begin
			if (sys_rst_i) begin
				count <= '0;
			end else if (wr_ok && !rd_go) begin
				count <= count + 1'h1;
			end else if (rd_go && !wr_ok) begin
				count <= count - 1'h1;
			end
		end

		// with the attenuator in the receive path reading starts at half depth, so the launch side has slack both ways
		always_ff @(posedge clock_i) begin
			if (sys_rst_i) begin
				fill_st <= LRD_FILLING;
			end else begin
				unique case (fill_st)
					LRD_FILLING: begin
						if (count >= fifo_thresh) begin
							fill_st <= LRD_DRAINING;
						end
					end
					LRD_DRAINING: begin
						if (count == '0) begin
							fill_st <= LRD_FILLING;
						end
					end
				endcase
			end
		end

		always_ff @(posedge clock_i) begin
			if (sys_rst_i) begin
				rd_pend <= 1'h0;
			end else begin
				rd_pend <= rd_go;
			end
		end

		lrd_fifo_mem #(
			.WIDTH  (WORD_W),
			.ADDR_W (FIFO_AW)
		) u_mem (
			.clock_i   (clock_i),
			.wr_en_i   (wr_ok),
			.wr_addr_i (wptr),
			.wr_data_i (emit),
			.rd_en_i   (rd_go),
			.rd_addr_i (rptr),
			.rd_data_o (mem_q)
		);

		// a read is only issued while the buffer has room, so the word read is never lost
		lrd_buffer2 #(
			.WIDTH (WORD_W)
		) u_buf (
			.clock_i     (clock_i),
			.sys_rst_i   (sys_rst_i),
			.in_valid_i  (rd_pend),
			.in_ready_o  (buf_in_ready),
			.in_data_i   (mem_q),
			.out_valid_o (buf_out_valid),
			.out_ready_i (launch),
			.out_data_o  (buf_out)
		);

		////////////////////////////////////////////////////////////////////////
		// output stage

		wire lrd_word_t head   = buf_out_valid ? lrd_word_t'(buf_out) : '0;
		wire            muted  = cfg_mute && los_s2;
		wire            nrz    = head.data_p || head.data_n;
		wire            rail_p = cfg_single ? nrz : head.data_p;
		wire            rail_n = cfg_single ? head.cv : head.data_n;

		always_ff @(posedge clock_i) begin
			if (sys_rst_i) begin
				recovered_clock_o[g] <= 1'h0;
			end else begin
				recovered_clock_o[g] <= rclk_s2;
			end
		end

		// every launch loads a fresh word, so a violation lasts one recovered clock
		always_ff @(posedge clock_i) begin
			if (sys_rst_i) begin
				positive_rail_out_o[g]   <= 1'h0;
				negative_rail_out_o[g]   <= 1'h0;
				loss_of_signal_flag_o[g] <= 1'h0;
			end else if (launch) begin
				positive_rail_out_o[g]   <= rail_p && !muted;
				negative_rail_out_o[g]   <= rail_n && !muted;
				loss_of_signal_flag_o[g] <= los_s2;
			end
		end

	end

endmodule // lrd_decode_outputs

`default_nettype wire

// [tb/lrd_decode_outputs_asserts.sv]
`timescale 1ns/10ps
`default_nettype none

module lrd_decode_outputs_asserts
	import lrd_pkg::*;
#(
	parameter int NCH = 4
) (
	input wire logic              clock_i,
	input wire logic              sys_rst_i,
	input wire logic [NCH-1:0]    rclk_i,
	input wire logic [NCH-1:0]    los_detect_i,
	input wire logic [REG_AW-1:0] reg_addr_i,
	input wire logic              reg_rd_i,
	input wire logic [REG_DW-1:0] reg_rdata_o,
	input wire logic [NCH-1:0]    recovered_clock_o,
	input wire logic [NCH-1:0]    positive_rail_out_o,
	input wire logic [NCH-1:0]    negative_rail_out_o,
	input wire logic [NCH-1:0]    loss_of_signal_flag_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);

	// channel 1 is the one the bench takes through a loss of signal
	sequence s_los_held;
		los_detect_i[1] [*6];
	endsequence
	sequence s_los_long;
		los_detect_i[1] [*8];
	endsequence
	sequence s_los_gone;
		(!los_detect_i[1]) [*8];
	endsequence

	////////////////////////////////////////////////////////////////////////////
	a_rd_idle_zero: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
		else $error("read data not zero outside read cycle");
	a_status_los_copy: assert property ($past(reg_rd_i) && $past(reg_addr_i) == STATUS_OFFSET
		|-> reg_rdata_o[3:0] == $past(loss_of_signal_flag_o[3:0]))
		else $error("status does not mirror loss flags");
	a_clk_follows_in: assert property (!($past(sys_rst_i, 1) || $past(sys_rst_i, 2) || $past(sys_rst_i, 3))
		|-> recovered_clock_o == $past(rclk_i, 3))
		else $error("recovered clock not three cycles behind input");
	a_los_with_clk: assert property (((loss_of_signal_flag_o ^ $past(loss_of_signal_flag_o))
		& ~(recovered_clock_o ^ $past(recovered_clock_o))) == '0)
		else $error("loss flag moved without a clock edge");
	a_pos_with_clk: assert property (((positive_rail_out_o ^ $past(positive_rail_out_o))
		& ~(recovered_clock_o ^ $past(recovered_clock_o))) == '0)
		else $error("positive rail moved without a clock edge");
	a_neg_with_clk: assert property (((negative_rail_out_o ^ $past(negative_rail_out_o))
		& ~(recovered_clock_o ^ $past(recovered_clock_o))) == '0)
		else $error("negative rail moved without a clock edge");
	a_los_raised: assert property (s_los_long |-> ##[0:8] loss_of_signal_flag_o[1])
		else $error("loss flag not raised in time");
	a_los_steady: assert property (s_los_held ##0 loss_of_signal_flag_o[1] |=> loss_of_signal_flag_o[1])
		else $error("loss flag dropped while loss persists");
	a_los_cleared: assert property (s_los_gone |-> ##[0:8] !loss_of_signal_flag_o[1])
		else $error("loss flag not cleared in time");
	a_reset_quiet: assert property ($past(sys_rst_i) |-> (positive_rail_out_o | negative_rail_out_o
		| loss_of_signal_flag_o | recovered_clock_o) == '0)
		else $error("outputs not zero after reset");
endmodule // lrd_decode_outputs_asserts

bind lrd_decode_outputs lrd_decode_outputs_asserts #(.NCH(NCH)) u_chk (
	.clock_i(clock_i), .sys_rst_i(sys_rst_i), .rclk_i(rclk_i), .los_detect_i(los_detect_i),
	.reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.recovered_clock_o(recovered_clock_o), .positive_rail_out_o(positive_rail_out_o),
	.negative_rail_out_o(negative_rail_out_o), .loss_of_signal_flag_o(loss_of_signal_flag_o)
);

`default_nettype wire

// [tb/lrd_line_framer_model.sv]
`timescale 1ns/10ps
`default_nettype none

// line side drives symbols, framer side counts ones at its sampling edge
module lrd_line_framer_model (
	input wire logic              clock_i,
	input wire logic              edge_sel_i,
	input wire logic [9:0]        pat_pos_i,
	input wire logic [9:0]        pat_neg_i,
	input wire logic [3:0]        rec_clk_i,
	input wire logic [3:0]        pos_i,
	input wire logic [3:0]        neg_i,
	input wire logic [3:0]        loss_i,
	output var logic [3:0]        rclk_o,
	output var logic [3:0]        rx_pos_o,
	output var logic [3:0]        rx_neg_o,
	output var logic [3:0][15:0]  p_cnt_o,
	output var logic [3:0][15:0]  n_cnt_o,
	output var logic [3:0][15:0]  l_cnt_o,
	output var logic [15:0]       s_cnt_o
);
	int         idx;
	logic [3:0] rc_q;
	logic [3:0] take;

	// sample on the edge opposite the launch edge, where rails are settled
	assign take = edge_sel_i ? (rc_q & ~rec_clk_i) : (~rc_q & rec_clk_i);

	////////////////////////////////////////////////////////////////////////////
	// free-running link clock, phase unrelated to clock_i; symbols move on its fall
	initial begin
		rclk_o = '0;
		rx_pos_o = '0;
		rx_neg_o = '0;
		idx = 0;
		#7;
		forever begin
			#80 rclk_o = ~rclk_o;
			if (!rclk_o[0]) begin
				rx_pos_o = {4{pat_pos_i[idx]}};
				rx_neg_o = {4{pat_neg_i[idx]}};
				idx = (idx + 1) % 10;
			end
		end
	end

	initial begin
		rc_q = '0;
		p_cnt_o = '0;
		n_cnt_o = '0;
		l_cnt_o = '0;
		s_cnt_o = '0;
		forever begin
			@(posedge clock_i);
			for (int c = 0; c < 4; c++) begin
				if (take[c]) begin
					p_cnt_o[c] <= p_cnt_o[c] + 16'(pos_i[c]);
					n_cnt_o[c] <= n_cnt_o[c] + 16'(neg_i[c]);
					l_cnt_o[c] <= l_cnt_o[c] + 16'(loss_i[c]);
				end
			end
			if (take[0])
				s_cnt_o <= s_cnt_o + 16'h0001;
			rc_q <= rec_clk_i;
		end
	end
endmodule // lrd_line_framer_model

`default_nettype wire

// [tb/lrd_decode_outputs_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin bad_count++; \
	$display("mismatch %s expected %0h seen %0h", nm, ex, got); end end

module lrd_decode_outputs_tb_top;
	import lrd_pkg::*;

	logic              clock_i, sys_rst_i, wr, rd, edge_sel;
	logic [3:0]        los, rclk, rxp, rxn, rc, rp, rn, rl;
	logic [7:0]        addr;
	logic [31:0]       wdata, rdata, d;
	logic [9:0]        pp, pn;
	logic [3:0][15:0]  pc, nc, lc, dp, dn, dl;
	logic [15:0]       sc;
	int                bad_count, check_count;

	lrd_decode_outputs dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .rclk_i(rclk), .rx_pos_i(rxp),
		.rx_neg_i(rxn), .los_detect_i(los), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_rdata_o(rdata), .recovered_clock_o(rc), .positive_rail_out_o(rp),
		.negative_rail_out_o(rn), .loss_of_signal_flag_o(rl));
	lrd_line_framer_model u_far (.clock_i(clock_i), .edge_sel_i(edge_sel), .pat_pos_i(pp), .pat_neg_i(pn),
		.rec_clk_i(rc), .pos_i(rp), .neg_i(rn), .loss_i(rl), .rclk_o(rclk), .rx_pos_o(rxp),
		.rx_neg_o(rxn), .p_cnt_o(pc), .n_cnt_o(nc), .l_cnt_o(lc), .s_cnt_o(sc));

	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock_i);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clock_i);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a);
		@(posedge clock_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock_i);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	// counts over exactly 20 framer samples, so window phase cannot skew totals
	task automatic measure();
		logic [15:0] s0;
		logic [3:0][15:0] p0, n0, l0;
		int t;
		s0 = sc;
		p0 = pc;
		n0 = nc;
		l0 = lc;
		t = 0;
		while (sc !== s0 + 16'h0014 && t < 400) begin
			@(posedge clock_i);
			t++;
		end
		// a framer that stopped sampling would otherwise end the loop silently
		`CHK("framer samples", s0 + 16'h0014, sc)
		for (int c = 0; c < 4; c++) begin
			dp[c] = pc[c] - p0[c];
			dn[c] = nc[c] - n0[c];
			dl[c] = lc[c] - l0[c];
		end
	endtask

	task automatic run_cfg(input logic [7:0] c, input logic [9:0] p, n, input logic [15:0] ep, en);
		wr_reg(CTRL_OFFSET, {24'h0, c});
		edge_sel <= c[CTRL_EDGE_BIT];
		pp <= p;
		pn <= n;
		repeat (480) @(posedge clock_i);
		measure();
		`CHK("rail p ch0", ep, dp[0])
		`CHK("rail n ch0", en, dn[0])
		`CHK("rail p ch3", ep, dp[3])
		$display("test cfg %0h done", c);
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		#500000;
		bad_count++;
		report_and_stop();
	end

	initial begin
		sys_rst_i = 1'b1;
		{wr, rd, edge_sel} = '0;
		{addr, wdata, los, pp, pn} = '0;
		bad_count = 0;
		check_count = 0;
		repeat (10) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		rd_reg(CTRL_OFFSET);
		`CHK("ctrl reset", 32'h00000000, d)
		rd_reg(STATUS_OFFSET);
		`CHK("status reset", 32'h00000000, d)
		wr_reg(8'h08, 32'hFFFFFFFF);
		rd_reg(8'h08);
		`CHK("unmapped", 32'h00000000, d)
		wr_reg(CTRL_OFFSET, 32'hFFFFFFFF);
		rd_reg(CTRL_OFFSET);
		`CHK("ctrl rw", 32'h000000FF, d)
		$display("test registers done");
		// alternating marks are legal; 10-slot pattern with two substitutions is not
		run_cfg(8'h00, 10'h155, 10'h2AA, 16'h000A, 16'h000A);
		run_cfg(8'h00, 10'h011, 10'h220, 16'h0004, 16'h0004);
		run_cfg(8'h04, 10'h155, 10'h2AA, 16'h0014, 16'h0000);
		run_cfg(8'h04, 10'h011, 10'h220, 16'h0008, 16'h0004);
		run_cfg(8'h05, 10'h011, 10'h220, 16'h0004, 16'h0000);
		// mark, then 000VB0VB in slots 1 to 8, then a mark: only the two marks survive
		run_cfg(8'h06, 10'h111, 10'h2A0, 16'h0004, 16'h0000);
		run_cfg(8'h14, 10'h155, 10'h2AA, 16'h0014, 16'h0000);
		run_cfg(8'h64, 10'h155, 10'h2AA, 16'h0014, 16'h0000);
		run_cfg(8'h24, 10'h155, 10'h2AA, 16'h0014, 16'h0000);
		los <= 4'b0010;
		run_cfg(8'h08, 10'h155, 10'h2AA, 16'h000A, 16'h000A);
		`CHK("muted p ch1", 16'h0000, dp[1])
		`CHK("muted n ch1", 16'h0000, dn[1])
		`CHK("loss ch1", 16'h0014, dl[1])
		`CHK("loss ch0", 16'h0000, dl[0])
		rd_reg(STATUS_OFFSET);
		`CHK("status loss", 8'h02, d[7:0])
		los <= 4'b0000;
		repeat (480) @(posedge clock_i);
		rd_reg(STATUS_OFFSET);
		`CHK("status clear", 8'h00, d[7:0])
		$display("test mute done");
		report_and_stop();
	end
endmodule // lrd_decode_outputs_tb_top

`default_nettype wire
